// ### design/tmr_chan_pkg.sv
// package: register map, field layout and encodings of the timer channel
package tmr_chan_pkg;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_COMPARE = 8'h04;
  localparam logic [7:0] OFF_OUT_EN = 8'h08;
  localparam logic [7:0] OFF_OUT_LVL = 8'h0c;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK = 8'h1c;
  localparam logic [7:0] OFF_PRESCALE = 8'h20;
  localparam int MODE_W = 16;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'hd7cf;
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam int CKS_LSB = 14;
  localparam int CCS_BIT = 12;
  localparam int STS_LSB = 8;
  localparam int CIS_LSB = 6;
  localparam int MD_LSB = 0;
  localparam int ST_TICK = 0;
  localparam int ST_START = 1;
  localparam int ST_CAPT = 2;
  localparam int ST_W = 3;

  typedef enum logic [2:0] {
    TRG_SOFT = 3'h0,
    TRG_EDGE = 3'h1,
    TRG_BOTH = 3'h2,
    TRG_MASTER = 3'h4
  } trig_src_t;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_LOW_W = 2'h2,
    EDGE_HIGH_W = 2'h3
  } edge_sel_t;

  typedef enum logic [2:0] {
    MD_INTERVAL = 3'h0,
    MD_CAPTURE = 3'h2,
    MD_EVENT = 3'h3,
    MD_ONE_COUNT = 3'h4,
    MD_CAPT_ONE = 3'h6
  } op_mode_t;

  typedef struct packed {
    logic [1:0] operation_clock_select;
    logic zero13;
    logic count_source_select;
    logic zero11;
    logic [2:0] trigger_source_field;
    logic [1:0] input_edge_field;
    logic [1:0] zero5_4;
    logic [2:0] operating_mode_field;
    logic start_behaviour_bit;
  } mode_reg_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_resp_t;
endpackage

// ### design/timer_channel_mode_control.sv
// timer channel: mode decode, counter, output control, apb registers
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module timer_channel_mode_control #(
  parameter int CNT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_prescale_tick,
  input wire logic i_master_irq,
  input wire logic i_in_pin,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output tmr_chan_pkg::apb_resp_t o_apb,
  output logic o_out_pin,
  output logic o_chan_irq_pulse,
  output logic o_irq
);
  import tmr_chan_pkg::*;

  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W out of range");
  end

  mode_reg_t mode_q;
  logic [CNT_W-1:0] compare_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] capt_q;
  logic out_en_q;
  logic out_lvl_q;
  logic running_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [1:0] pin_sync_q;
  logic pin_prev_q;
  logic irq_pulse_q;
  logic [31:0] prdata_q;
  logic soft_start;
  logic soft_stop;

  // input pin synchroniser; stage 0 read only by stage 1
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_sync_q <= 2'b00;
      pin_prev_q <= 1'b0;
    end else if (i_ce) begin
      pin_sync_q <= {pin_sync_q[0], i_in_pin};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  // no edges until the sync pipe holds real samples; pin may idle high
  logic [1:0] fill_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fill_q <= 2'h0;
    end else if (i_ce && !(&fill_q)) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  logic armed;
  logic pin_rise;
  logic pin_fall;
  assign armed = &fill_q;
  assign pin_rise = armed & pin_sync_q[1] & ~pin_prev_q;
  assign pin_fall = armed & ~pin_sync_q[1] & pin_prev_q;

  edge_sel_t edge_sel;
  trig_src_t trig_src;
  op_mode_t op_mode;
  assign edge_sel = edge_sel_t'(mode_q.input_edge_field);
  assign trig_src = trig_src_t'(mode_q.trigger_source_field);
  assign op_mode = op_mode_t'(mode_q.operating_mode_field);

  // valid edge, start edge and capture edge of the input pin
  logic valid_edge;
  logic start_edge;
  logic capt_edge;
  always_comb begin
    valid_edge = 1'b0;
    start_edge = 1'b0;
    capt_edge = 1'b0;
    unique case (edge_sel)
      EDGE_FALL: begin
        valid_edge = pin_fall;
        start_edge = pin_fall;
        capt_edge = pin_fall;
      end
      EDGE_RISE: begin
        valid_edge = pin_rise;
        start_edge = pin_rise;
        capt_edge = pin_rise;
      end
      EDGE_LOW_W: begin
        valid_edge = pin_fall | pin_rise;
        start_edge = pin_fall;
        capt_edge = pin_rise;
      end
      EDGE_HIGH_W: begin
        valid_edge = pin_fall | pin_rise;
        start_edge = pin_rise;
        capt_edge = pin_fall;
      end
    endcase
  end

  // hardware trigger; prohibited codes give no trigger
  logic hw_start;
  logic hw_capt;
  always_comb begin
    hw_start = 1'b0;
    hw_capt = 1'b0;
    case (trig_src)
      TRG_SOFT: begin
        hw_start = 1'b0;
      end
      TRG_EDGE: begin
        hw_start = start_edge;
        hw_capt = capt_edge;
      end
      TRG_BOTH: begin
        hw_start = pin_rise | pin_fall;
        hw_capt = pin_rise | pin_fall;
      end
      TRG_MASTER: begin
        hw_start = i_master_irq;
      end
      default: begin
        hw_start = 1'b0;
      end
    endcase
  end

  // operation clock select and count clock source
  logic op_tick;
  always_comb begin
    op_tick = 1'b0;
    unique case (mode_q.operation_clock_select)
      2'b00: op_tick = i_prescale_tick[0];
      2'b01: op_tick = i_prescale_tick[2];
      2'b10: op_tick = i_prescale_tick[1];
      2'b11: op_tick = i_prescale_tick[3];
    endcase
  end

  logic cnt_tick;
  assign cnt_tick = mode_q.count_source_select ? valid_edge : op_tick;

  logic mode_legal;
  logic count_down;
  assign mode_legal = (op_mode == MD_INTERVAL) || (op_mode == MD_CAPTURE) ||
                      (op_mode == MD_EVENT) || (op_mode == MD_ONE_COUNT) ||
                      (op_mode == MD_CAPT_ONE);
  assign count_down = (op_mode == MD_INTERVAL) || (op_mode == MD_EVENT) ||
                      (op_mode == MD_ONE_COUNT);

  // start qualification per mode
  logic start_req;
  logic start_take;
  logic start_irq;
  assign start_req = (soft_start | hw_start) & mode_legal;
  always_comb begin
    start_take = 1'b0;
    start_irq = 1'b0;
    case (op_mode)
      MD_INTERVAL, MD_CAPTURE: begin
        start_take = start_req;
        start_irq = start_req & mode_q.start_behaviour_bit;
      end
      MD_EVENT: begin
        start_take = start_req;
      end
      MD_ONE_COUNT: begin
        start_take = start_req &
                     (~running_q | mode_q.start_behaviour_bit);
        start_irq = start_take & running_q;
      end
      MD_CAPT_ONE: begin
        start_take = start_req & ~running_q;
      end
      default: begin
        start_take = 1'b0;
      end
    endcase
  end

  // counter events
  logic wrap;
  logic capt_ev;
  logic capt_one_end;
  assign wrap = running_q & ~start_take & cnt_tick & count_down &
                (cnt_q == '0);
  assign capt_ev = running_q & ~start_take & (op_mode == MD_CAPTURE) & hw_capt;
  assign capt_one_end = running_q & (op_mode == MD_CAPT_ONE) & hw_capt;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
      running_q <= 1'b0;
    end else if (i_ce) begin
      if (soft_stop) begin
        running_q <= 1'b0;
      end else if (start_take) begin
        running_q <= 1'b1;
        cnt_q <= count_down ? compare_q : '0;
      end else if (capt_one_end) begin
        running_q <= 1'b0;
      end else if (capt_ev) begin
        cnt_q <= '0;
      end else if (running_q && cnt_tick) begin
        if (!count_down) begin
          cnt_q <= cnt_q + 1'b1;
        end else if (cnt_q == '0) begin
          if (op_mode == MD_ONE_COUNT) begin
            running_q <= 1'b0;
          end else begin
            cnt_q <= compare_q;
          end
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      capt_q <= '0;
    end else if (i_ce && (capt_ev || capt_one_end)) begin
      capt_q <= cnt_q;
    end
  end

  logic chan_event;
  assign chan_event = start_irq | wrap | capt_ev | capt_one_end;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_pulse_q <= 1'b0;
    end else if (i_ce) begin
      irq_pulse_q <= chan_event;
    end
  end
  assign o_chan_irq_pulse = irq_pulse_q;

  // apb decode
  logic acc;
  logic wr;
  logic [31:0] wdata;
  assign acc = i_psel & i_penable;
  assign wr = acc & i_pwrite;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wdata[b*8 +: 8] = i_pstrb[b] ? i_pwdata[b*8 +: 8] : 8'h00;
    end
  end
  assign soft_start = wr & (i_paddr == OFF_CTRL) & i_pstrb[0] & i_pwdata[0];
  assign soft_stop = wr & (i_paddr == OFF_CTRL) & i_pstrb[0] & i_pwdata[1];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_q <= mode_reg_t'(MODE_RST);
      compare_q <= CNT_W'(COMPARE_RST);
      mask_q <= '0;
      out_en_q <= 1'b0;
    end else if (i_ce && wr) begin
      case (i_paddr)
        OFF_MODE: begin
          if (i_pstrb[1:0] == 2'b11) begin
            mode_q <= mode_reg_t'(i_pwdata[15:0] & MODE_WMASK);
          end
        end
        OFF_COMPARE: compare_q <= wdata[CNT_W-1:0];
        OFF_MASK: mask_q <= wdata[ST_W-1:0];
        OFF_OUT_EN: out_en_q <= wdata[0];
        default: ;
      endcase
    end
  end

  // output level: timer toggles or software writes
  logic toggle;
  assign toggle = start_irq & (op_mode != MD_ONE_COUNT) | wrap |
                  (op_mode == MD_ONE_COUNT) & start_take;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      out_lvl_q <= 1'b0;
    end else if (i_ce) begin
      if (out_en_q) begin
        if (toggle) begin
          out_lvl_q <= ~out_lvl_q;
        end
      end else if (wr && i_paddr == OFF_OUT_LVL && i_pstrb[0]) begin
        out_lvl_q <= i_pwdata[0];
      end
    end
  end
  assign o_out_pin = out_lvl_q;

  // sticky status, set wins over write-one-to-clear
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;
  always_comb begin
    st_set = '0;
    st_set[ST_TICK] = wrap;
    st_set[ST_START] = start_irq;
    st_set[ST_CAPT] = capt_ev | capt_one_end;
  end
  assign st_clr = (wr && i_paddr == OFF_STATUS) ? wdata[ST_W-1:0] : '0;
  for (genvar s = 0; s < ST_W; s++) begin : g_status
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        status_q[s] <= 1'b0;
      end else if (i_ce) begin
        if (st_set[s]) begin
          status_q[s] <= 1'b1;
        end else if (st_clr[s]) begin
          status_q[s] <= 1'b0;
        end
      end
    end
  end
  assign o_irq = |(status_q & mask_q);

  // read data registered at the setup cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prdata_q <= 32'h0;
    end else if (i_ce && i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        OFF_MODE: prdata_q <= {16'h0, mode_q};
        OFF_COMPARE: prdata_q <= 32'(compare_q);
        OFF_OUT_EN: prdata_q <= {31'h0, out_en_q};
        OFF_OUT_LVL: prdata_q <= {31'h0, out_lvl_q};
        OFF_CTRL: prdata_q <= {31'h0, running_q};
        OFF_COUNT: prdata_q <= 32'(cnt_q);
        OFF_STATUS: prdata_q <= 32'(status_q);
        OFF_MASK: prdata_q <= 32'(mask_q);
        OFF_PRESCALE: prdata_q <= 32'(capt_q);
        default: prdata_q <= 32'h0;
      endcase
    end
  end

  logic mapped;
  assign mapped = (i_paddr[1:0] == 2'b00) && (i_paddr <= OFF_PRESCALE);
  assign o_apb.prdata = prdata_q;
  assign o_apb.pready = i_ce;
  assign o_apb.pslverr = acc & ~mapped;
endmodule

// ### tb/tmr_chan_asserts.sv
// port-level assertion checker for the timer channel
`timescale 1ns/1ps
module tmr_chan_asserts
  import tmr_chan_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_prescale_tick,
  input wire logic i_master_irq,
  input wire logic i_in_pin,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input tmr_chan_pkg::apb_resp_t o_apb,
  input wire logic o_out_pin,
  input wire logic o_chan_irq_pulse,
  input wire logic o_irq
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic acc, bad, wsm, oe_q;
  assign acc = i_psel && i_penable && i_ce;
  assign bad = i_paddr > OFF_PRESCALE || i_paddr[1:0] != 2'h0;
  assign wsm = acc && i_pwrite && (i_paddr == OFF_STATUS
    || i_paddr == OFF_MASK);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      oe_q <= 1'b0;
    end else if (acc && i_pwrite && i_paddr == OFF_OUT_EN) begin
      oe_q <= i_pstrb[0] && i_pwdata[0];
    end
  end
  ready_follows_a: assert property (i_psel && i_penable
    |-> o_apb.pready == i_ce) else $error("pready wrong");
  unmapped_err_a: assert property (i_psel && i_penable && bad
    |-> o_apb.pslverr) else $error("no slave error");
  unmapped_zero_a: assert property (acc && !i_pwrite && bad
    |-> o_apb.prdata == 32'h0) else $error("unmapped data");
  rdata_hold_a: assert property ($changed(o_apb.prdata) |-> $past(i_sys_rst)
    || $past(i_psel && !i_penable && !i_pwrite)) else $error("prdata moved");
  soft_level_a: assert property (!oe_q && $past(!oe_q) && $changed(o_out_pin)
    |-> $past(acc && i_pwrite && i_paddr == OFF_OUT_LVL))
    else $error("pin moved");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(wsm) || $past(wsm, 2)
    || $past(i_sys_rst)) else $error("irq dropped");
  reset_quiet_a: assert property (disable iff (1'b0) i_sys_rst
    |=> !o_irq && !o_chan_irq_pulse && !o_out_pin) else $error("reset");
  freeze_a: assert property (!i_ce |=> $stable(o_out_pin) && $stable(o_irq))
    else $error("not frozen");
  cover property (o_chan_irq_pulse);
  cover property ($rose(o_irq));
  cover property (acc && bad);
endmodule

bind timer_channel_mode_control tmr_chan_asserts u_tmr_chan_asserts (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
  .i_prescale_tick(i_prescale_tick), .i_master_irq(i_master_irq),
  .i_in_pin(i_in_pin), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_apb(o_apb), .o_out_pin(o_out_pin),
  .o_chan_irq_pulse(o_chan_irq_pulse), .o_irq(o_irq)
);

// ### tb/timer_channel_mode_control_test.sv
// self-checking bench for the timer channel
`timescale 1ns/1ps
module timer_channel_mode_control_test;
  import tmr_chan_pkg::*;
  logic clk = 1'b0;
  logic rst, ce, mirq, pin, psel, pen, pwr, serr, opin, pulse, irq;
  logic [3:0] tick, strb;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  apb_resp_t resp;
  int err_total = 0;
  int n_tests = 0;
  int np = 0;
  int base;
  int sel[4] = '{0, 2, 1, 3};
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (pulse === 1'b1) np <= np + 1;
  end
  timer_channel_mode_control u_timer_channel_mode_control (
    .i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_prescale_tick(tick),
    .i_master_irq(mirq), .i_in_pin(pin), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .i_pstrb(strb),
    .o_apb(resp), .o_out_pin(opin), .o_chan_irq_pulse(pulse), .o_irq(irq)
  );
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    strb <= s;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (resp.pready !== 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
    end
    if (n == 40) begin
      err_total++;
      stop_test();
    end else begin
      rdata = resp.prdata;
      serr = resp.pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rdata, e);
  endtask
  task automatic ticks(input int i, input int k);
    repeat (k) begin
      tick[i] <= 1'b1;
      @(posedge clk);
      tick <= 4'h0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic pin_to(input logic v);
    pin <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic clr();
    wr(OFF_CTRL, 32'h2);
    wr(OFF_STATUS, 32'h7);
  endtask
  initial begin
    {rst, ce, tick, mirq, pin, psel, pen, pwr, addr, wdata, strb} = '0;
    rst = 1'b1;
    ce = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFF_MODE, {16'h0, MODE_RST});
    rd(OFF_COMPARE, {16'h0, COMPARE_RST});
    bus(1'b1, OFF_MODE, 32'hffff, 4'h1);
    rd(OFF_MODE, {16'h0, MODE_RST});
    wr(OFF_MODE, 32'hffff);
    rd(OFF_MODE, {16'h0, MODE_WMASK});
    bus(1'b0, 8'h40, 32'h0, 4'hf);
    chk({31'h0, serr}, 32'h1);
    wr(OFF_COMPARE, 32'h2);
    for (int c = 0; c < 4; c++) begin
      wr(OFF_MODE, c << CKS_LSB);
      wr(OFF_CTRL, 32'h1);
      base = np;
      ticks(sel[c], 6);
      ticks(sel[(c + 1) % 4], 3);
      chk(np - base, 32'h2);
    end
    wr(OFF_STATUS, 32'h7);
    ticks(3, 3);
    rd(OFF_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    clr();
    wr(OFF_OUT_EN, 32'h1);
    wr(OFF_OUT_LVL, 32'h1);
    chk({31'h0, opin}, 32'h0);
    wr(OFF_MODE, 32'h1);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_STATUS, 32'h2);
    chk({31'h0, opin}, 32'h1);
    ticks(0, 3);
    chk({31'h0, opin}, 32'h0);
    clr();
    wr(OFF_OUT_EN, 32'h0);
    wr(OFF_OUT_LVL, 32'h1);
    chk({31'h0, opin}, 32'h1);
    wr(OFF_MODE, 32'h0);
    wr(OFF_CTRL, 32'h1);
    ce <= 1'b0;
    ticks(0, 2);
    ce <= 1'b1;
    rd(OFF_COUNT, 32'h2);
    wr(OFF_COMPARE, 32'h1);
    for (int e = 0; e < 2; e++) begin
      pin_to(1'b0);
      wr(OFF_MODE, 32'h1006 | (e << CIS_LSB));
      wr(OFF_CTRL, 32'h1);
      base = np;
      pin_to(1'b1);
      pin_to(1'b0);
      pin_to(1'b1);
      chk(np - base, e);
      clr();
    end
    for (int w = 2; w < 4; w++) begin
      pin_to(w == 2);
      wr(OFF_MODE, 32'h10c | (w << CIS_LSB));
      wr(OFF_CTRL, 32'h1);
      pin_to(w != 2);
      rd(OFF_STATUS, 32'h0);
      pin_to(w == 2);
      rd(OFF_STATUS, 32'h4);
      clr();
    end
    for (int m = 0; m < 2; m++) begin
      wr(OFF_MODE, 32'h8 | m);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_STATUS, 32'h7);
      wr(OFF_CTRL, 32'h1);
      rd(OFF_STATUS, m << 1);
      ticks(0, 2);
      rd(OFF_CTRL, 32'h0);
      clr();
    end
    wr(OFF_MODE, 32'h401);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_STATUS, 32'h7);
    mirq <= 1'b1;
    @(posedge clk);
    mirq <= 1'b0;
    repeat (3) @(posedge clk);
    rd(OFF_STATUS, 32'h2);
    stop_test();
  end
endmodule
